/* File: card_side_model.sv */
`timescale 1ns/1ps
module card_side_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic feed_enable,
  input wire logic [7:0] load_n,
  input wire logic load_stb,
  input wire logic fail_cmd,
  input wire logic punch_cmd,
  input wire logic fault_cmd,
  output logic cycle_strobe,
  output logic hopper_empty,
  output logic feed_empty,
  output logic feed_fail,
  output logic punch_start,
  output logic punch_done,
  output logic punch_fault
);
  logic [2:0] cyc_q;
  logic [7:0] hopper_q;
  logic [1:0] feed_q;
  logic tick;
  // ==========================================================================
  // machine cycle timing
  // ==========================================================================
  assign tick = (cyc_q == 3'h7);
  assign cycle_strobe = cyc_q[2];
  assign hopper_empty = (hopper_q == 8'h00);
  assign feed_empty = (feed_q == 2'h0);
  always_ff @(posedge ref_clk) begin
    if (rst) cyc_q <= 3'h0;
    else cyc_q <= cyc_q + 3'h1;
  end
  // ==========================================================================
  // card feed: hopper, two held stations
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hopper_q <= 8'h00;
      feed_q <= 2'h0;
      feed_fail <= 1'b0;
    end else if (load_stb) begin
      // operator empties or refills the hopper before recovery
      hopper_q <= load_n;
      feed_fail <= 1'b0;
    end else if (tick && feed_enable) begin
      if (hopper_q != 8'h00 && fail_cmd) begin
        feed_fail <= 1'b1;
      end else if (hopper_q != 8'h00) begin
        hopper_q <= hopper_q - 8'h01;
        if (feed_q != 2'h2) feed_q <= feed_q + 2'h1;
      end else if (feed_q != 2'h0) begin
        // cards still held run out, a blank card clears the feed
        feed_q <= feed_q - 2'h1;
      end
    end
  end
  // ==========================================================================
  // summary punch
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      punch_start <= 1'b0;
      punch_done <= 1'b0;
      punch_fault <= 1'b0;
    end else if (tick) begin
      punch_start <= punch_cmd;
      if (punch_start && !punch_cmd) begin
        punch_done <= !fault_cmd;
        punch_fault <= fault_cmd;
      end else begin
        punch_done <= 1'b0;
        // fault stands until the punch side corrects it
        punch_fault <= punch_fault & fault_cmd;
      end
    end
  end
endmodule

/* File: run_control.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - feeding begins only on start; start resumes after any non-interlock stop (code: runout and interlock keys also feed; stop light blocks start)
// RULE_02 - stop key halts the machine before the next card feeds
// RULE_03 - a running or pending program cycle finishes before the stop
// RULE_04 - final-total clear needs idle, empty hopper, empty feed, start with final key
// RULE_05 - idle light on while powered and idling
// RULE_06 - machine-stop entry impulse halts and lights the stop light
// RULE_07 - no restart while stop light lit; final-total key extinguishes it
// RULE_08 - blown fuse halts and lights the fuse light
// RULE_09 - form within 10 inches of platen halts and lights the form light
// RULE_10 - card-feed-stop light on at punch start or feed interlock
// RULE_11 - failed punch keeps card-feed-stop lit and blocks operation until fixed
// RULE_12 - each of 3 setup switches drives its exit continuously while on
// RULE_13 - setup exits cannot select first-card or special switch functions
// RULE_14 - non-print runout runs cards out unprinted, only with empty hopper
// RULE_15 - feed failure from hopper halts with later-station cards kept
// RULE_16 - after feed failure only the interlock key, hopper emptied, restarts
// RULE_17 - interlock runout stacks both held cards; later card skips compare only (code: both held cards run out adding, with compare and print off)
// RULE_18 - reinserted held card only compares; following cards normal
// RULE_19 - abandoned run: one blank card through clears the interlock (code: start stays blocked by card-feed-stop while interlocked)
// RULE_20 - gang punch switch on with cable attached inhibits this machine
// RULE_21 - keys sampled once per machine cycle, one event per depression
module run_control #(
  parameter int setup_count_p = run_control_pkg::setup_count
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic power_on,
  input wire logic cycle_strobe,
  input wire logic [setup_count_p-1:0] setup_select_switch,
  input wire logic no_balance_switch,
  input wire logic inverse_feed_switch,
  input wire logic special_program_switch,
  input wire logic gang_punch_switch,
  input wire logic punch_cable_attached,
  input wire logic machine_stop_impulse,
  input wire logic fuse_blown,
  input wire logic form_low,
  input wire logic hopper_empty,
  input wire logic feed_empty,
  input wire logic feed_fail,
  input wire logic program_pending,
  input wire logic punch_start,
  input wire logic punch_done,
  input wire logic punch_fault,
  input wire logic first_card_impulse,
  output logic feed_enable,
  output logic program_run,
  output logic final_total_clear,
  output logic idle_light,
  output logic stop_light,
  output logic fuse_light,
  output logic form_light,
  output logic card_feed_stop_light,
  output logic print_enable,
  output logic add_enable,
  output logic compare_enable,
  output logic [setup_count_p-1:0] setup_exit,
  output logic [setup_count_p-1:0] setup_sel_first_card,
  output logic no_balance_fn,
  output logic inverse_feed_fn,
  output logic special_program_fn
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  localparam int nsync = 18 + setup_count_p;
  logic [nsync-1:0] raw;
  logic [nsync-1:0] s1_q;
  logic [nsync-1:0] s2_q;
  assign raw = {setup_select_switch, power_on, cycle_strobe, no_balance_switch, inverse_feed_switch,
                special_program_switch, gang_punch_switch, punch_cable_attached, machine_stop_impulse,
                fuse_blown, form_low, hopper_empty, feed_empty, feed_fail, program_pending,
                punch_start, punch_done, punch_fault, first_card_impulse};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic pwr, cyc, nbal, invf, splp, gang, cable, mstop, fuse, form, hempty, fempty, ffail;
  logic ppend, pstart, pdone, pfault, fcard;
  logic [setup_count_p-1:0] sus;
  assign {sus, pwr, cyc, nbal, invf, splp, gang, cable, mstop, fuse, form, hempty, fempty, ffail,
          ppend, pstart, pdone, pfault, fcard} = s2_q;

  // ==========================================================================
  // machine cycle edge and key latching
  // ==========================================================================
  logic cyc_q;
  logic cycle_tick;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_q <= 1'b0;
    end else begin
      cyc_q <= cyc;
    end
  end
  assign cycle_tick = cyc & ~cyc_q;

  // software key writes latch; consumed at next machine cycle (set wins over clear)
  run_control_pkg::keys_s key_req_q;
  run_control_pkg::keys_s key_q;
  logic wr_ctrl;
  assign wr_ctrl = avs_write && (avs_address == run_control_pkg::ctrl_offset);
  run_control_pkg::keys_s wr_keys;
  assign wr_keys = run_control_pkg::keys_s'({avs_writedata[run_control_pkg::ctrl_start_bit],
                   avs_writedata[run_control_pkg::ctrl_stop_bit],
                   avs_writedata[run_control_pkg::ctrl_final_total_bit],
                   avs_writedata[run_control_pkg::ctrl_runout_bit],
                   avs_writedata[run_control_pkg::ctrl_interlock_bit]});
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      key_req_q <= '0;
      key_q <= '0;
    end else begin
      if (cycle_tick) begin
        key_q <= key_req_q; // RULE_21
      end else begin
        key_q <= '0;
      end
      // a press landing on the tick is kept; the pending ones were just handed over
      if (wr_ctrl && cycle_tick) begin
        key_req_q <= wr_keys; // RULE_21
      end else if (wr_ctrl) begin
        key_req_q <= key_req_q | wr_keys;
      end else if (cycle_tick) begin
        key_req_q <= '0; // RULE_21
      end
    end
  end

  // ==========================================================================
  // indicator lights
  // ==========================================================================
  logic mstop_q, fuse_q, form_q, cfs_q, ilock_q, runout_q, stop_req_q, blank_q;
  run_control_pkg::run_state_e state_q;
  logic inhibit;
  assign inhibit = gang && cable; // RULE_20
  logic blocked;
  assign blocked = mstop_q | fuse_q | form_q | cfs_q | inhibit;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mstop_q <= 1'b0;
      fuse_q <= 1'b0;
      form_q <= 1'b0;
    end else begin
      if (mstop) begin
        mstop_q <= 1'b1; // RULE_06
      end else if (key_q.final_total) begin
        mstop_q <= 1'b0; // RULE_07
      end
      fuse_q <= fuse; // RULE_08
      form_q <= form; // RULE_09
    end
  end

  // card-feed-stop: punch start, punch fault or interlock sets; clean punch or interlock runout clears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfs_q <= 1'b0;
    end else if (pstart || ffail || pfault) begin
      cfs_q <= 1'b1; // RULE_10 RULE_11
    end else if (pdone && !ilock_q) begin
      cfs_q <= 1'b0; // RULE_11
    end else if (state_q == run_control_pkg::st_ilock && cycle_tick && fempty) begin
      cfs_q <= 1'b0; // RULE_16
    end
  end

  // ==========================================================================
  // run sequencer
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= run_control_pkg::st_idle;
      stop_req_q <= 1'b0;
      ilock_q <= 1'b0;
      runout_q <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      unique case (state_q)
        run_control_pkg::st_idle: begin
          if (key_q.interlock && ilock_q && hempty && !fuse_q && !mstop_q && !inhibit) begin
            state_q <= run_control_pkg::st_ilock; // RULE_16
          end else if (key_q.runout && hempty && !blocked && !ilock_q) begin
            runout_q <= 1'b1; // RULE_14
            state_q <= run_control_pkg::st_run;
          end else if (key_q.start && !key_q.final_total && !blocked) begin
            blank_q <= ilock_q; // RULE_19
            state_q <= run_control_pkg::st_run; // RULE_01 RULE_07
          end
        end
        run_control_pkg::st_run: begin
          if (key_q.stop) begin
            stop_req_q <= 1'b1;
          end
          if (ffail) begin
            ilock_q <= 1'b1; // RULE_15
            state_q <= run_control_pkg::st_idle;
          end else if (blocked) begin
            state_q <= run_control_pkg::st_idle; // RULE_06 RULE_08 RULE_09 RULE_20
          end else if (cycle_tick && ppend) begin
            state_q <= run_control_pkg::st_prog; // RULE_03
          end else if (cycle_tick && (stop_req_q || key_q.stop)) begin
            stop_req_q <= 1'b0;
            state_q <= run_control_pkg::st_idle; // RULE_02
          end else if (cycle_tick && fempty && hempty) begin
            runout_q <= 1'b0;
            if (blank_q) begin
              ilock_q <= 1'b0; // RULE_19
              blank_q <= 1'b0;
            end
            state_q <= run_control_pkg::st_idle;
          end
        end
        run_control_pkg::st_prog: begin
          if (key_q.stop) begin
            stop_req_q <= 1'b1;
          end
          if (fuse_q || inhibit) begin
            state_q <= run_control_pkg::st_idle;
          end else if (cycle_tick && !ppend) begin
            if (stop_req_q || key_q.stop) begin
              stop_req_q <= 1'b0;
              state_q <= run_control_pkg::st_idle; // RULE_03
            end else begin
              state_q <= run_control_pkg::st_run;
            end
          end
        end
        run_control_pkg::st_ilock: begin
          // held cards run out; restart of run with held card comes after
          if (cycle_tick && fempty) begin
            ilock_q <= 1'b0;
            state_q <= run_control_pkg::st_idle; // RULE_17
          end
        end
        default: begin
          state_q <= run_control_pkg::st_idle;
        end
      endcase
    end
  end

  // held card reinserted: first card of the resumed run only compares
  logic held_q;
  logic held_arm_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      held_arm_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      if (state_q == run_control_pkg::st_ilock && cycle_tick && fempty) begin
        held_arm_q <= 1'b1;
      end else if (held_arm_q && state_q == run_control_pkg::st_run && cycle_tick) begin
        held_arm_q <= 1'b0;
      end
      if (held_arm_q && state_q == run_control_pkg::st_run && cycle_tick) begin
        held_q <= 1'b1; // RULE_18
      end else if (cycle_tick) begin
        held_q <= 1'b0; // RULE_18
      end
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      feed_enable <= 1'b0;
      program_run <= 1'b0;
      final_total_clear <= 1'b0;
      idle_light <= 1'b0;
      stop_light <= 1'b0;
      fuse_light <= 1'b0;
      form_light <= 1'b0;
      card_feed_stop_light <= 1'b0;
      print_enable <= 1'b0;
      add_enable <= 1'b0;
      compare_enable <= 1'b0;
      setup_exit <= '0;
      setup_sel_first_card <= '0;
      no_balance_fn <= 1'b0;
      inverse_feed_fn <= 1'b0;
      special_program_fn <= 1'b0;
    end else begin
      feed_enable <= (state_q == run_control_pkg::st_run) || (state_q == run_control_pkg::st_ilock);
      program_run <= state_q == run_control_pkg::st_prog;
      final_total_clear <= (state_q == run_control_pkg::st_idle) && hempty && fempty
                           && key_q.start && key_q.final_total; // RULE_04
      idle_light <= pwr && (state_q == run_control_pkg::st_idle); // RULE_05
      stop_light <= mstop_q; // RULE_06
      fuse_light <= fuse_q; // RULE_08
      form_light <= form_q; // RULE_09
      card_feed_stop_light <= cfs_q | ilock_q; // RULE_10
      print_enable <= (state_q == run_control_pkg::st_run) && !runout_q && !held_q; // RULE_14 RULE_18
      add_enable <= (state_q == run_control_pkg::st_run || state_q == run_control_pkg::st_ilock)
                    && !held_q; // RULE_17 RULE_18
      compare_enable <= (state_q == run_control_pkg::st_run); // RULE_17
      setup_exit <= sus; // RULE_12
      // setup exits never reach these paths; first-card select is tied to zero, the other three follow only the operator switches
      setup_sel_first_card <= '0; // RULE_13
      no_balance_fn <= nbal; // RULE_13
      inverse_feed_fn <= invf; // RULE_13
      special_program_fn <= splp; // RULE_13
    end
  end

  // ==========================================================================
  // avalon slave: writes zero wait, read data registered with waitrequest one cycle
  // ==========================================================================
  logic rd_done_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_done_q <= 1'b0;
      avs_readdata <= run_control_pkg::reset_value;
    end else begin
      rd_done_q <= avs_read && !rd_done_q;
      if (avs_read && !rd_done_q) begin
        unique case (avs_address)
          run_control_pkg::status_offset: begin
            avs_readdata <= {24'h00_0000, runout_q, ilock_q, cfs_q, form_q, fuse_q, mstop_q,
                             state_q == run_control_pkg::st_idle, state_q != run_control_pkg::st_idle};
          end
          run_control_pkg::setup_offset: begin
            avs_readdata <= {{(32 - setup_count_p){1'b0}}, sus};
          end
          default: begin
            avs_readdata <= run_control_pkg::unmapped_value;
          end
        endcase
      end
    end
  end
  assign avs_waitrequest = avs_read && !rd_done_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence s_stop_seen;
    mstop;
  endsequence
  a_mstop_light: assert property (@(posedge ref_clk) disable iff (rst)
    s_stop_seen |-> ##2 stop_light) else $error("stop light not lit"); // RULE_06
  a_no_restart: assert property (@(posedge ref_clk) disable iff (rst)
    mstop_q && state_q == run_control_pkg::st_idle |=> state_q == run_control_pkg::st_idle)
    else $error("restart with stop light"); // RULE_07
  a_fuse_halt: assert property (@(posedge ref_clk) disable iff (rst)
    fuse_q && state_q == run_control_pkg::st_run |=> state_q == run_control_pkg::st_idle)
    else $error("no halt on fuse"); // RULE_08
  a_form_light: assert property (@(posedge ref_clk) disable iff (rst)
    form_q |=> form_light) else $error("form light off"); // RULE_09
  a_ftc_cond: assert property (@(posedge ref_clk) disable iff (rst)
    final_total_clear |-> $past(hempty) && $past(fempty)) else $error("bad clear"); // RULE_04
  a_gang_inhibit: assert property (@(posedge ref_clk) disable iff (rst)
    inhibit && state_q == run_control_pkg::st_idle |=> state_q == run_control_pkg::st_idle)
    else $error("ran with gang punch"); // RULE_20
  a_fail_ilock: assert property (@(posedge ref_clk) disable iff (rst)
    ffail && state_q == run_control_pkg::st_run |=> ilock_q) else $error("interlock not set"); // RULE_15
  a_setup_exit: assert property (@(posedge ref_clk) disable iff (rst)
    setup_exit == $past(sus)) else $error("setup exit wrong"); // RULE_12
  a_runout_noprint: assert property (@(posedge ref_clk) disable iff (rst)
    runout_q |=> !print_enable) else $error("printed on runout"); // RULE_14
endmodule

/* File: run_control_pkg.sv */
package run_control_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] status_offset = 4'h4;
  localparam logic [3:0] setup_offset = 4'h8;

  // control register fields (write: one-shot key presses, read: zero)
  localparam int ctrl_start_bit = 0;
  localparam int ctrl_stop_bit = 1;
  localparam int ctrl_final_total_bit = 2;
  localparam int ctrl_runout_bit = 3;
  localparam int ctrl_interlock_bit = 4;

  // status register fields
  localparam int st_run_bit = 0;
  localparam int st_idle_bit = 1;
  localparam int st_mstop_bit = 2;
  localparam int st_fuse_bit = 3;
  localparam int st_form_bit = 4;
  localparam int st_cfs_bit = 5;
  localparam int st_interlock_bit = 6;
  localparam int st_runout_bit = 7;

  localparam logic [31:0] unmapped_value = 32'h0000_0000;
  localparam logic [31:0] reset_value = 32'h0000_0000;
  localparam int setup_count = 3;

  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_run = 4'b0010,
    st_prog = 4'b0100,
    st_ilock = 4'b1000
  } run_state_e;

  // operator keys gathered into one bundle
  typedef struct packed {
    logic start;
    logic stop;
    logic final_total;
    logic runout;
    logic interlock;
  } keys_s;

endpackage

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic power_on = 1'b1, nb_sw = 1'b0, inv_sw = 1'b0, spl_sw = 1'b0, gang_sw = 1'b0, cable = 1'b0;
  logic mstop = 1'b0, fuse = 1'b0, form = 1'b0, pend = 1'b0, first_card = 1'b0, load_stb = 1'b0;
  logic fail_cmd = 1'b0, punch_cmd = 1'b0, fault_cmd = 1'b0, ftc_seen = 1'b0, fed, printed;
  logic [2:0] setup_sw = 3'h0, setup_exit, sel_first;
  logic [7:0] load_n = 8'h00;
  logic cyc, h_empty, f_empty, f_fail, p_start, p_done, p_fault;
  logic feed_enable, program_run, ftc, idle_light, stop_light, fuse_light, form_light, cfs_light;
  logic print_enable, add_enable, compare_enable, nb_fn, inv_fn, spl_fn;
  int n_mismatch = 0, tests_run = 0;

  run_control uut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_on(power_on), .cycle_strobe(cyc),
    .setup_select_switch(setup_sw), .no_balance_switch(nb_sw), .inverse_feed_switch(inv_sw),
    .special_program_switch(spl_sw), .gang_punch_switch(gang_sw), .punch_cable_attached(cable),
    .machine_stop_impulse(mstop), .fuse_blown(fuse), .form_low(form), .hopper_empty(h_empty),
    .feed_empty(f_empty), .feed_fail(f_fail), .program_pending(pend), .punch_start(p_start),
    .punch_done(p_done), .punch_fault(p_fault), .first_card_impulse(first_card),
    .feed_enable(feed_enable), .program_run(program_run), .final_total_clear(ftc),
    .idle_light(idle_light), .stop_light(stop_light), .fuse_light(fuse_light), .form_light(form_light),
    .card_feed_stop_light(cfs_light), .print_enable(print_enable), .add_enable(add_enable),
    .compare_enable(compare_enable), .setup_exit(setup_exit), .setup_sel_first_card(sel_first),
    .no_balance_fn(nb_fn), .inverse_feed_fn(inv_fn), .special_program_fn(spl_fn));

  card_side_model partner (.ref_clk(ref_clk), .rst(rst), .feed_enable(feed_enable), .load_n(load_n),
    .load_stb(load_stb), .fail_cmd(fail_cmd), .punch_cmd(punch_cmd), .fault_cmd(fault_cmd),
    .cycle_strobe(cyc), .hopper_empty(h_empty), .feed_empty(f_empty), .feed_fail(f_fail),
    .punch_start(p_start), .punch_done(p_done), .punch_fault(p_fault));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // the clear pulse stands one cycle only, so it is caught here
  always @(posedge ref_clk) begin
    if (ftc === 1'b1) ftc_seen <= 1'b1;
  end
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) n_mismatch++;
    @(posedge ref_clk);
  endtask
  task automatic key(input int b);
    // let pin changes made just before the press pass the synchronisers
    repeat (4) @(posedge ref_clk);
    bus(1'b0, run_control_pkg::ctrl_offset, 32'h0000_0001 << b);
  endtask
  task automatic settle();
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic load(input logic [7:0] n);
    load_n <= n;
    load_stb <= 1'b1;
    @(posedge ref_clk);
    load_stb <= 1'b0;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    #(100 * 30000);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    check_bit(idle_light, 1'b1);
    check_bit(feed_enable, 1'b0);
    power_on <= 1'b0;
    settle();
    check_bit(idle_light, 1'b0);
    power_on <= 1'b1;
    load(8'h20);
    key(run_control_pkg::ctrl_start_bit);
    settle();
    check_bit(feed_enable, 1'b1);
    check_bit(idle_light, 1'b0);
    check_bit(print_enable, 1'b1);
    check_bit(add_enable, 1'b1);
    check_bit(compare_enable, 1'b1);
    key(run_control_pkg::ctrl_stop_bit);
    settle();
    check_bit(feed_enable, 1'b0);
    key(run_control_pkg::ctrl_runout_bit);
    settle();
    check_bit(feed_enable, 1'b0);
    load(8'h00);
    key(run_control_pkg::ctrl_runout_bit);
    fed = 1'b0;
    printed = 1'b0;
    repeat (40) begin
      @(posedge ref_clk);
      fed = fed | (feed_enable === 1'b1);
      printed = printed | (print_enable !== 1'b0);
    end
    check_bit(fed, 1'b1);
    check_bit(printed, 1'b0);
    load(8'h20);
    key(run_control_pkg::ctrl_start_bit);
    pend <= 1'b1;
    settle();
    key(run_control_pkg::ctrl_stop_bit);
    settle();
    check_bit(program_run, 1'b1);
    pend <= 1'b0;
    settle();
    check_bit(program_run, 1'b0);
    check_bit(feed_enable, 1'b0);
    key(run_control_pkg::ctrl_start_bit);
    mstop <= 1'b1;
    settle();
    mstop <= 1'b0;
    check_bit(stop_light, 1'b1);
    check_bit(feed_enable, 1'b0);
    key(run_control_pkg::ctrl_start_bit);
    settle();
    check_bit(feed_enable, 1'b0);
    key(run_control_pkg::ctrl_final_total_bit);
    settle();
    check_bit(stop_light, 1'b0);
    for (int i = 0; i < 2; i++) begin
      key(run_control_pkg::ctrl_start_bit);
      settle();
      check_bit(feed_enable, 1'b1);
      fuse <= (i == 0);
      form <= (i == 1);
      settle();
      check_bit(i == 0 ? fuse_light : form_light, 1'b1);
      check_bit(feed_enable, 1'b0);
      fuse <= 1'b0;
      form <= 1'b0;
    end
    gang_sw <= 1'b1;
    cable <= 1'b1;
    key(run_control_pkg::ctrl_start_bit);
    settle();
    check_bit(feed_enable, 1'b0);
    cable <= 1'b0;
    key(run_control_pkg::ctrl_start_bit);
    settle();
    check_bit(feed_enable, 1'b1);
    gang_sw <= 1'b0;
    punch_cmd <= 1'b1;
    settle();
    check_bit(cfs_light, 1'b1);
    fault_cmd <= 1'b1;
    punch_cmd <= 1'b0;
    settle();
    check_bit(cfs_light, 1'b1);
    check_bit(feed_enable, 1'b0);
    fault_cmd <= 1'b0;
    punch_cmd <= 1'b1;
    settle();
    punch_cmd <= 1'b0;
    settle();
    check_bit(cfs_light, 1'b0);
    fail_cmd <= 1'b1;
    key(run_control_pkg::ctrl_start_bit);
    settle();
    check_bit(feed_enable, 1'b0);
    check_bit(cfs_light, 1'b1);
    bus(1'b1, run_control_pkg::status_offset, 32'h0000_0000);
    check_bit(q[run_control_pkg::st_interlock_bit], 1'b1);
    fail_cmd <= 1'b0;
    key(run_control_pkg::ctrl_start_bit);
    settle();
    check_bit(feed_enable, 1'b0);
    load(8'h00);
    key(run_control_pkg::ctrl_interlock_bit);
    fed = 1'b0;
    printed = 1'b0;
    repeat (40) begin
      @(posedge ref_clk);
      fed = fed | (add_enable === 1'b1);
      printed = printed | (compare_enable !== 1'b0);
    end
    check_bit(fed, 1'b1);
    check_bit(printed, 1'b0);
    settle();
    bus(1'b1, run_control_pkg::status_offset, 32'h0000_0000);
    check_bit(q[run_control_pkg::st_interlock_bit], 1'b0);
    ftc_seen <= 1'b0;
    bus(1'b0, run_control_pkg::ctrl_offset, 32'h0000_0005);
    settle();
    check_bit(ftc_seen, 1'b1);
    check_bit(feed_enable, 1'b0);
    load(8'h05);
    ftc_seen <= 1'b0;
    bus(1'b0, run_control_pkg::ctrl_offset, 32'h0000_0005);
    settle();
    check_bit(ftc_seen, 1'b0);
    for (int i = 0; i < 8; i++) begin
      setup_sw <= i[2:0];
      nb_sw <= i[0];
      inv_sw <= i[1];
      spl_sw <= i[2];
      first_card <= i[0];
      repeat (8) @(posedge ref_clk);
      check_word({29'h0000_0000, setup_exit}, i);
      check_word({29'h0000_0000, sel_first}, 32'h0000_0000);
      check_word({29'h0000_0000, spl_fn, inv_fn, nb_fn}, i);
      bus(1'b1, run_control_pkg::setup_offset, 32'h0000_0000);
      check_word(q, i);
    end
    bus(1'b1, 4'hc, 32'h0000_0000);
    check_word(q, run_control_pkg::unmapped_value);
    stop_test();
  end
endmodule
